/* File: src/panel_ctrl_pkg.sv */
`default_nettype none
package panel_ctrl_pkg;

  // Clock rate and documented times, each in its own unit
  localparam longint unsigned CLK_KHZ = 250000;
  localparam longint unsigned FALLBACK_MS = 4000;
  localparam longint unsigned DEBOUNCE_MS = 10;
  localparam longint unsigned BLINK_HALF_MS = 500;
  localparam longint unsigned PGOOD_DELAY_MS = 100;
  localparam longint unsigned RESET_HOLD_MS = 1;

  // Cycle counts derived from the times above
  localparam int unsigned FALLBACK_CYCLES = 32'(FALLBACK_MS * CLK_KHZ);
  localparam int unsigned DEBOUNCE_CYCLES = 32'(DEBOUNCE_MS * CLK_KHZ);
  localparam int unsigned BLINK_HALF_CYCLES = 32'(BLINK_HALF_MS * CLK_KHZ);
  localparam int unsigned PGOOD_DELAY_CYCLES = 32'(PGOOD_DELAY_MS * CLK_KHZ);
  localparam int unsigned RESET_HOLD_CYCLES = 32'(RESET_HOLD_MS * CLK_KHZ);

  // Correctable memory errors tolerated before the degraded state
  localparam logic [15:0] MEM_ERR_LIMIT = 16'h000a;

  // Register offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FAULTS = 8'h04;
  localparam logic [7:0] OFS_MEM_ERR = 8'h08;
  localparam logic [7:0] OFS_IDENT = 8'h0c;
  localparam logic [7:0] OFS_POWER = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;

  // Field positions
  localparam int unsigned CTRL_READY_BIT = 0;
  localparam int unsigned FAULT_DEG_LSB = 0;
  localparam int unsigned FAULT_NC_LSB = 8;
  localparam int unsigned FAULT_FATAL_LSB = 16;
  localparam int unsigned MEM_SPARED_BIT = 16;
  localparam int unsigned PWR_SUPPLY_BIT = 8;
  localparam int unsigned PWR_PGOOD_BIT = 9;
  localparam int unsigned PWR_ID_LSB = 12;
  localparam int unsigned PWR_GREEN_BIT = 16;
  localparam int unsigned PWR_AMBER_BIT = 17;
  localparam int unsigned PWR_ID_LAMP_BIT = 18;
  localparam int unsigned IRQ_PWR_PRESS = 0;
  localparam int unsigned IRQ_RST_PRESS = 1;
  localparam int unsigned IRQ_ID_PRESS = 2;
  localparam int unsigned IRQ_FORCED_OFF = 3;
  localparam int unsigned IRQ_POWERED_UP = 4;
  localparam int unsigned IRQ_W = 5;

  // Values after reset
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 5'h00;
  localparam logic [23:0] FAULTS_RST = 24'h000000;

  // Power sequencer states
  typedef enum logic [4:0] {
    PWR_OFF = 5'b00001,
    PWR_RAMP = 5'b00010,
    PWR_RESET = 5'b00100,
    PWR_ON = 5'b01000,
    PWR_DOWN = 5'b10000
  } pwr_state_t;

  // Identify lamp modes, also the code software writes
  typedef enum logic [2:0] {
    ID_OFF = 3'b001,
    ID_BLINK = 3'b010,
    ID_SOLID = 3'b100
  } id_mode_t;

endpackage
`default_nettype wire

/* File: src/input_filter.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser followed by a stability counter
module input_filter #(
  parameter int unsigned DEBOUNCE_CYCLES = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic raw_in,
  output logic level_out,
  output logic rise_out
);
  typedef struct packed {
    logic [2:0] sync;
    logic [31:0] cnt;
    logic level;
    logic rise;
  } filt_t;

  filt_t q;
  filt_t d;

  // A change counts once stages two and three agree for the full count
  always_comb begin
    d = q;
    d.sync = {q.sync[1:0], raw_in};
    d.rise = 1'b0;
    if (q.sync[2] == q.sync[1] && q.sync[2] != q.level) begin
      if (q.cnt >= DEBOUNCE_CYCLES - 1) begin
        d.level = q.sync[2];
        d.rise = q.sync[2];
        d.cnt = '0;
      end else begin
        d.cnt = 32'(q.cnt + 32'h1);
      end
    end else begin
      d.cnt = '0; // Bounce restarts the wait
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.level;
  assign rise_out = q.rise;
endmodule // input_filter
`default_nettype wire

/* File: src/blink_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Free-running square wave shared by all blinking lamps
module blink_timer #(
  parameter int unsigned HALF_CYCLES = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  output logic phase_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
  } blink_t;

  blink_t q;
  blink_t d;

  // Toggle every half period
  always_comb begin
    d = q;
    if (q.cnt >= HALF_CYCLES - 1) begin
      d.cnt = '0;
      d.phase = ~q.phase;
    end else begin
      d.cnt = 32'(q.cnt + 32'h1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase_out = q.phase;
endmodule // blink_timer
`default_nettype wire

/* File: src/panel_power_ctrl.sv */
// Contract
// - Button or wake while off starts power-up
// - Power button becomes request to chipset
// - Drop supply once chipset enters off
// - Unserviced off request forces off after timeout
// - Reset button forwarded as chipset reset request unless off
// - Steady green when booted and ready
// - Blink green on degraded conditions
// - Over ten memory errors with spare: degraded
// - Blink amber on non-fatal alarms
// - Steady amber on fatal conditions
// - Dark when off and no faults
// - Newest indicator request cancels earlier ones
// - Identify press: blink to solid, then off
`timescale 1ns/1ps
`default_nettype none
module panel_power_ctrl #(
  parameter int unsigned FALLBACK_CYCLES = panel_ctrl_pkg::FALLBACK_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = panel_ctrl_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned BLINK_HALF_CYCLES = panel_ctrl_pkg::BLINK_HALF_CYCLES,
  parameter int unsigned PGOOD_DELAY_CYCLES = panel_ctrl_pkg::PGOOD_DELAY_CYCLES,
  parameter int unsigned RESET_HOLD_CYCLES = panel_ctrl_pkg::RESET_HOLD_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  input wire logic panel_power_button_low_in,
  input wire logic panel_reset_button_low_in,
  input wire logic panel_identify_button_low_in,
  input wire logic chipset_wake_in,
  input wire logic chipset_off_state_in,
  input wire logic catastrophic_error_in,
  input wire logic thermal_trip_in,
  output logic supply_power_on_out,
  output logic power_good_out,
  output logic platform_reset_low_out,
  output logic chipset_power_request_out,
  output logic chipset_reset_request_out,
  output logic health_lamp_green_low_out,
  output logic health_lamp_amber_low_out,
  output logic identify_lamp_low_out,
  output logic irq_out
);
  localparam int unsigned N_IN = 7;
  localparam int unsigned IN_PWR = 0;
  localparam int unsigned IN_RST = 1;
  localparam int unsigned IN_ID = 2;
  localparam int unsigned IN_WAKE = 3;
  localparam int unsigned IN_OFF = 4;
  localparam int unsigned IN_CAT = 5;
  localparam int unsigned IN_TRIP = 6;
  localparam int unsigned IRQ_W = panel_ctrl_pkg::IRQ_W;

  typedef struct packed {
    panel_ctrl_pkg::pwr_state_t pwr;
    logic [31:0] cnt;
    logic supply_on;
    logic pgood;
    logic rst_act;
    logic pwr_req;
    logic rst_req;
    panel_ctrl_pkg::id_mode_t id;
    logic ready;
    logic [23:0] faults;
    logic [15:0] mem_cnt;
    logic spared;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
    logic green_low;
    logic amber_low;
    logic id_low;
    logic irq;
  } state_t;

  localparam state_t RESET_STATE = '{
    pwr: panel_ctrl_pkg::PWR_OFF,
    id: panel_ctrl_pkg::ID_OFF,
    faults: panel_ctrl_pkg::FAULTS_RST,
    irq_en: panel_ctrl_pkg::IRQ_EN_RST,
    rst_act: 1'b1,
    green_low: 1'b1,
    amber_low: 1'b1,
    id_low: 1'b1,
    default: '0
  };

  // Legal identify codes are one-hot; anything else is ignored
  function automatic logic id_code_ok(input logic [2:0] code);
    return code == panel_ctrl_pkg::ID_OFF || code == panel_ctrl_pkg::ID_BLINK ||
      code == panel_ctrl_pkg::ID_SOLID;
  endfunction

  // Register decode used by both the write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  state_t q;
  state_t d;
  logic [N_IN-1:0] raw;
  logic [N_IN-1:0] level;
  logic [N_IN-1:0] rise;
  logic blink;
  logic fatal;
  logic alarm;
  logic degraded;
  logic mem_degraded;
  logic healthy;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clear;

  // Buttons are inverted so every filtered level is active high
  assign raw = {thermal_trip_in, catastrophic_error_in, chipset_off_state_in,
    chipset_wake_in, ~panel_identify_button_low_in, ~panel_reset_button_low_in,
    ~panel_power_button_low_in};

  // Only the mechanical buttons pay the debounce delay
  generate
    for (genvar i = 0; i < N_IN; i++) begin : g_in
      input_filter #(
        .DEBOUNCE_CYCLES(i <= IN_ID ? DEBOUNCE_CYCLES : 1)
      ) u_filter (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .raw_in(raw[i]),
        .level_out(level[i]),
        .rise_out(rise[i])
      );
    end
  endgenerate

  blink_timer #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .phase_out(blink)
  );

  // Health classification, worst condition first
  always_comb begin
    mem_degraded = q.spared && (q.mem_cnt > panel_ctrl_pkg::MEM_ERR_LIMIT);
    fatal = (|q.faults[panel_ctrl_pkg::FAULT_FATAL_LSB +: 8]) || level[IN_TRIP];
    alarm = (|q.faults[panel_ctrl_pkg::FAULT_NC_LSB +: 8]) || level[IN_CAT];
    degraded = (|q.faults[panel_ctrl_pkg::FAULT_DEG_LSB +: 8]) || mem_degraded;
    healthy = q.ready && (q.pwr == panel_ctrl_pkg::PWR_ON);
  end

  // Main next-state logic
  always_comb begin
    d = q;
    d.pwr_req = 1'b0;
    d.rst_req = 1'b0;
    d.rdata = '0;
    events = '0;
    clear = '0;

    // Power sequencer
    unique case (q.pwr)
      panel_ctrl_pkg::PWR_OFF: begin
        if (rise[IN_PWR] || rise[IN_WAKE]) begin
          d.pwr = panel_ctrl_pkg::PWR_RAMP;
          d.supply_on = 1'b1;
          d.cnt = '0;
        end
      end
      panel_ctrl_pkg::PWR_RAMP: begin
        if (q.cnt >= PGOOD_DELAY_CYCLES - 1) begin
          d.pwr = panel_ctrl_pkg::PWR_RESET;
          d.pgood = 1'b1;
          d.cnt = '0;
        end else begin
          d.cnt = 32'(q.cnt + 32'h1);
        end
      end
      panel_ctrl_pkg::PWR_RESET: begin
        if (q.cnt >= RESET_HOLD_CYCLES - 1) begin
          d.pwr = panel_ctrl_pkg::PWR_ON;
          d.rst_act = 1'b0;
          d.cnt = '0;
          events[panel_ctrl_pkg::IRQ_POWERED_UP] = 1'b1;
        end else begin
          d.cnt = 32'(q.cnt + 32'h1);
        end
      end
      panel_ctrl_pkg::PWR_ON: begin
        if (rise[IN_OFF]) begin
          d.pwr = panel_ctrl_pkg::PWR_OFF;
        end else if (rise[IN_PWR]) begin
          // The button never cuts the supply itself; the chipset or the fallback timeout does
          d.pwr_req = 1'b1;
          d.pwr = panel_ctrl_pkg::PWR_DOWN;
          d.cnt = '0;
        end
      end
      panel_ctrl_pkg::PWR_DOWN: begin
        if (rise[IN_OFF]) begin
          d.pwr = panel_ctrl_pkg::PWR_OFF;
        end else if (q.cnt >= FALLBACK_CYCLES - 1) begin
          d.pwr = panel_ctrl_pkg::PWR_OFF;
          events[panel_ctrl_pkg::IRQ_FORCED_OFF] = 1'b1;
        end else begin
          d.cnt = 32'(q.cnt + 32'h1);
        end
      end
    endcase

    // Any move into off drops the supply and re-arms platform reset
    if (d.pwr == panel_ctrl_pkg::PWR_OFF && q.pwr != panel_ctrl_pkg::PWR_OFF) begin
      d.supply_on = 1'b0;
      d.pgood = 1'b0;
      d.rst_act = 1'b1;
      d.cnt = '0;
    end

    // Reset button forwarded whenever power is not off; no software register can block it
    if (rise[IN_RST] && q.pwr != panel_ctrl_pkg::PWR_OFF) begin
      d.rst_req = 1'b1;
    end

    // Identify lamp: press steps the mode, a command below replaces it
    if (rise[IN_ID]) begin
      unique case (q.id)
        panel_ctrl_pkg::ID_BLINK: d.id = panel_ctrl_pkg::ID_SOLID;
        panel_ctrl_pkg::ID_SOLID: d.id = panel_ctrl_pkg::ID_OFF;
        panel_ctrl_pkg::ID_OFF: d.id = panel_ctrl_pkg::ID_SOLID;
      endcase
    end

    events[panel_ctrl_pkg::IRQ_PWR_PRESS] = rise[IN_PWR];
    events[panel_ctrl_pkg::IRQ_RST_PRESS] = rise[IN_RST];
    events[panel_ctrl_pkg::IRQ_ID_PRESS] = rise[IN_ID];

    // Register writes
    if (reg_write_in) begin
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_CONTROL)) begin
        d.ready = reg_wdata_in[panel_ctrl_pkg::CTRL_READY_BIT];
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_FAULTS)) begin
        d.faults = reg_wdata_in[23:0];
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_MEM_ERR)) begin
        d.mem_cnt = reg_wdata_in[15:0];
        d.spared = reg_wdata_in[panel_ctrl_pkg::MEM_SPARED_BIT];
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_IDENT) && id_code_ok(reg_wdata_in[2:0])) begin
        d.id = panel_ctrl_pkg::id_mode_t'(reg_wdata_in[2:0]);
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_IRQ_CLEAR)) begin
        clear = reg_wdata_in[IRQ_W-1:0];
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_IRQ_ENABLE)) begin
        d.irq_en = reg_wdata_in[IRQ_W-1:0];
      end
    end

    // A new event in the clearing cycle survives the clear
    d.irq_st = (q.irq_st & ~clear) | events;
    d.irq = |(d.irq_st & d.irq_en);

    // Register reads; data stand for the one following cycle
    if (reg_read_in) begin
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_CONTROL)) begin
        d.rdata[panel_ctrl_pkg::CTRL_READY_BIT] = q.ready;
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_FAULTS)) begin
        d.rdata[23:0] = q.faults;
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_MEM_ERR)) begin
        d.rdata[15:0] = q.mem_cnt;
        d.rdata[panel_ctrl_pkg::MEM_SPARED_BIT] = q.spared;
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_IDENT)) begin
        d.rdata[2:0] = q.id;
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_POWER)) begin
        d.rdata[4:0] = q.pwr;
        d.rdata[panel_ctrl_pkg::PWR_SUPPLY_BIT] = q.supply_on;
        d.rdata[panel_ctrl_pkg::PWR_PGOOD_BIT] = q.pgood;
        d.rdata[panel_ctrl_pkg::PWR_ID_LSB +: 3] = q.id;
        d.rdata[panel_ctrl_pkg::PWR_GREEN_BIT] = ~q.green_low;
        d.rdata[panel_ctrl_pkg::PWR_AMBER_BIT] = ~q.amber_low;
        d.rdata[panel_ctrl_pkg::PWR_ID_LAMP_BIT] = ~q.id_low;
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_IRQ_STATUS)) begin
        d.rdata[IRQ_W-1:0] = q.irq_st;
      end
      if (hit(reg_addr_in, panel_ctrl_pkg::OFS_IRQ_ENABLE)) begin
        d.rdata[IRQ_W-1:0] = q.irq_en;
      end
    end

    // Health lamp; the worst condition present wins
    d.green_low = 1'b1;
    d.amber_low = 1'b1;
    if (fatal) begin
      d.amber_low = 1'b0;
    end else if (alarm) begin
      d.amber_low = ~blink;
    end else if (degraded) begin
      d.green_low = ~blink;
    end else if (healthy) begin
      d.green_low = 1'b0;
    end else begin
      d.green_low = 1'b1;
    end

    // Identify lamp drive follows the mode already stored
    unique case (q.id)
      panel_ctrl_pkg::ID_SOLID: d.id_low = 1'b0;
      panel_ctrl_pkg::ID_BLINK: d.id_low = ~blink;
      panel_ctrl_pkg::ID_OFF: d.id_low = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from the state register
  assign reg_rdata_out = q.rdata;
  assign supply_power_on_out = q.supply_on;
  assign power_good_out = q.pgood;
  assign platform_reset_low_out = ~q.rst_act;
  assign chipset_power_request_out = q.pwr_req;
  assign chipset_reset_request_out = q.rst_req;
  assign health_lamp_green_low_out = q.green_low;
  assign health_lamp_amber_low_out = q.amber_low;
  assign identify_lamp_low_out = q.id_low;
  assign irq_out = q.irq;
endmodule // panel_power_ctrl
`default_nettype wire

/* File: testbench/panel_power_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module panel_power_ctrl_asserts #(
  parameter int FALLBACK_CYCLES = 200,
  parameter int PGOOD_DELAY_CYCLES = 10,
  parameter int RESET_HOLD_CYCLES = 5
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic chipset_off_state_in,
  input wire logic thermal_trip_in,
  input wire logic supply_power_on_out,
  input wire logic power_good_out,
  input wire logic platform_reset_low_out,
  input wire logic chipset_power_request_out,
  input wire logic chipset_reset_request_out,
  input wire logic health_lamp_green_low_out,
  input wire logic health_lamp_amber_low_out
);
  // Slack for the pipeline between the request pulse and the fallback counter
  localparam int FB_MAX = FALLBACK_CYCLES + 4;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Power-up steps: supply first, then power good, then reset release
  sequence s_good_after_supply;
    ##PGOOD_DELAY_CYCLES $rose(power_good_out);
  endsequence
  sequence s_release_after_good;
    ##RESET_HOLD_CYCLES $rose(platform_reset_low_out);
  endsequence
  pgood_delay_a: assert property ($rose(supply_power_on_out) |-> s_good_after_supply)
    else $error("power good late or early after supply on");
  reset_release_a: assert property ($rose(power_good_out) |-> s_release_after_good)
    else $error("platform reset release off its delay");
  reset_held_a: assert property (!power_good_out |-> !platform_reset_low_out)
    else $error("platform out of reset without power good");
  pgood_supply_a: assert property (power_good_out |-> supply_power_on_out)
    else $error("power good without supply on");
  power_req_a: assert property (
    chipset_power_request_out |-> platform_reset_low_out ##1 !chipset_power_request_out)
    else $error("power request outside on state or too long");
  off_drop_a: assert property (
    $rose(chipset_off_state_in) && platform_reset_low_out |-> ##[1:8] !supply_power_on_out)
    else $error("supply kept on after chipset went off");
  fallback_a: assert property (
    $rose(chipset_power_request_out) |-> ##[1:FB_MAX] !supply_power_on_out)
    else $error("no forced off after the fallback time");
  reset_fwd_a: assert property (
    chipset_reset_request_out |-> supply_power_on_out ##1 !chipset_reset_request_out)
    else $error("reset request while off or too long");
  fatal_amber_a: assert property (thermal_trip_in [*8] |=>
    !health_lamp_amber_low_out && health_lamp_green_low_out)
    else $error("thermal trip not shown as steady amber");
  one_colour_a: assert property (!health_lamp_amber_low_out |-> health_lamp_green_low_out)
    else $error("green and amber lit together");
endmodule // panel_power_ctrl_asserts
bind panel_power_ctrl panel_power_ctrl_asserts #(
  .FALLBACK_CYCLES(FALLBACK_CYCLES),
  .PGOOD_DELAY_CYCLES(PGOOD_DELAY_CYCLES),
  .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)
) panel_power_ctrl_asserts_i (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .chipset_off_state_in(chipset_off_state_in),
  .thermal_trip_in(thermal_trip_in),
  .supply_power_on_out(supply_power_on_out),
  .power_good_out(power_good_out),
  .platform_reset_low_out(platform_reset_low_out),
  .chipset_power_request_out(chipset_power_request_out),
  .chipset_reset_request_out(chipset_reset_request_out),
  .health_lamp_green_low_out(health_lamp_green_low_out),
  .health_lamp_amber_low_out(health_lamp_amber_low_out)
);
`default_nettype wire

/* File: testbench/chipset_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Chipset power logic with firmware behind it, as the controller sees it
module chipset_model #(
  parameter int SERVE_DELAY = 20
) (
  input wire logic ref_clk_in,
  input wire logic power_request_in,
  input wire logic reset_request_in,
  input wire logic supply_on_in,
  input wire logic serve_in,
  input wire logic wake_cmd_in,
  output logic wake_out,
  output logic off_state_out,
  output logic [7:0] resets_out
);
  logic supply_q = 1'b0;
  int wait_q = -1;
  // System starts out off
  initial begin
    wake_out = 1'b0;
    off_state_out = 1'b1;
    resets_out = 8'h00;
  end
  // Off state rises only when firmware serves the request, and holds
  // until the supply returns, so the controller sees one clean edge
  always @(posedge ref_clk_in) begin
    wake_out <= wake_cmd_in;
    supply_q <= supply_on_in;
    if (reset_request_in) begin
      resets_out <= resets_out + 8'h01;
    end
    if (power_request_in && serve_in) begin
      wait_q <= SERVE_DELAY;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (wait_q == 0) begin
      wait_q <= -1;
      off_state_out <= 1'b1;
    end
    if (supply_on_in && !supply_q) begin
      off_state_out <= 1'b0;
    end
  end
endmodule // chipset_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int FB = 200;
  localparam int DB = 4;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0, rd_en = 1'b0, pwr_low = 1'b1, rbtn_low = 1'b1, id_btn_low = 1'b1;
  logic cat_err = 1'b0, therm = 1'b0, serve = 1'b1, wake_cmd = 1'b0;
  logic wake, off_state, supply, pgood, prst_low, pwr_req, rst_req, green_low, amber_low;
  logic id_low, irq;
  logic [31:0] rdata;
  logic [7:0] resets;
  int bad_count = 0, checked = 0, n, g, a, k;
  // Lamp cases: fault word, memory errors, {catastrophic, thermal}, {green, amber} lit cycles
  logic [31:0] t_flt [0:7] = '{32'h1, 32'h0, 32'h0, 32'h100, 32'h10000, 32'h0, 32'h0, 32'h0};
  logic [31:0] t_mem [0:7] = '{32'h0, 32'h1000a, 32'h1000b, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [1:0] t_pin [0:7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
  logic [15:0] t_exp [0:7] = '{16'h1000, 16'h2000, 16'h1000, 16'h0010, 16'h0020, 16'h0010,
    16'h0020, 16'h2000};

  panel_power_ctrl #(.FALLBACK_CYCLES(FB), .DEBOUNCE_CYCLES(DB), .BLINK_HALF_CYCLES(8),
    .PGOOD_DELAY_CYCLES(10), .RESET_HOLD_CYCLES(5)) panel_power_ctrl_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
    .panel_power_button_low_in(pwr_low), .panel_reset_button_low_in(rbtn_low),
    .panel_identify_button_low_in(id_btn_low), .chipset_wake_in(wake),
    .chipset_off_state_in(off_state), .catastrophic_error_in(cat_err),
    .thermal_trip_in(therm), .supply_power_on_out(supply), .power_good_out(pgood),
    .platform_reset_low_out(prst_low), .chipset_power_request_out(pwr_req),
    .chipset_reset_request_out(rst_req), .health_lamp_green_low_out(green_low),
    .health_lamp_amber_low_out(amber_low), .identify_lamp_low_out(id_low), .irq_out(irq));
  chipset_model chipset_model_i (.ref_clk_in(ref_clk_in), .power_request_in(pwr_req),
    .reset_request_in(rst_req), .supply_on_in(supply), .serve_in(serve),
    .wake_cmd_in(wake_cmd), .wake_out(wake), .off_state_out(off_state), .resets_out(resets));

  always #2 ref_clk_in = ~ref_clk_in;

  // Comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Register port cycles: one strobe cycle, read data in the next cycle only
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= ad;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk_in);
    wr_en <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    @(posedge ref_clk_in);
    addr <= ad;
    rd_en <= 1'b1;
    @(posedge ref_clk_in);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Bounded wait: 0 for release of platform reset, 1 for supply off
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (n < lim && !(sel == 0 ? prst_low === 1'b1 : supply === 1'b0)) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test;
    end
  endtask
  // Button held well past the debounce time, then released as long
  task automatic press(input int b);
    @(posedge ref_clk_in);
    pwr_low <= (b != 0);
    rbtn_low <= (b != 1);
    id_btn_low <= (b != 2);
    repeat (DB + 8) @(posedge ref_clk_in);
    pwr_low <= 1'b1;
    rbtn_low <= 1'b1;
    id_btn_low <= 1'b1;
    repeat (DB + 8) @(posedge ref_clk_in);
  endtask
  // Lit cycles of each lamp over two blink periods
  task automatic watch;
    g = 0;
    a = 0;
    k = 0;
    repeat (32) begin
      @(posedge ref_clk_in);
      #1 g += (green_low === 1'b0);
      a += (amber_low === 1'b0);
      k += (id_low === 1'b0);
    end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1 chk(32'({supply, pgood, prst_low, green_low, amber_low, id_low, irq}), 32'h0e);
    rchk(panel_ctrl_pkg::OFS_FAULTS, 32'h0);
    wr(8'h24, 32'hffffffff);
    rchk(8'h24, 32'h0);
    wr(panel_ctrl_pkg::OFS_IRQ_ENABLE, 32'h1f);
    // A bounce shorter than the debounce time must not start power-up
    @(posedge ref_clk_in);
    pwr_low <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    pwr_low <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    #1 chk(32'(supply), 32'h0);
    press(0);
    wait_for(0, 100);
    chk(32'({supply, pgood}), 32'h3);
    rchk(panel_ctrl_pkg::OFS_IRQ_STATUS, 32'h11);
    chk(32'(irq), 32'h1);
    wr(panel_ctrl_pkg::OFS_IRQ_CLEAR, 32'h1f);
    rchk(panel_ctrl_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    // Reset press with interrupts masked, then unmasked
    wr(panel_ctrl_pkg::OFS_IRQ_ENABLE, 32'h0);
    press(1);
    chk(32'(resets), 32'h1);
    rchk(panel_ctrl_pkg::OFS_IRQ_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
    wr(panel_ctrl_pkg::OFS_IRQ_ENABLE, 32'h1f);
    repeat (2) @(posedge ref_clk_in);
    #1 chk(32'(irq), 32'h1);
    // Health lamp under each class of condition, newest write replacing the last
    wr(panel_ctrl_pkg::OFS_CONTROL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(panel_ctrl_pkg::OFS_FAULTS, t_flt[i]);
      wr(panel_ctrl_pkg::OFS_MEM_ERR, t_mem[i]);
      {cat_err, therm} <= t_pin[i];
      repeat (16) @(posedge ref_clk_in);
      watch;
      chk(32'(g * 256 + a), 32'(t_exp[i]));
    end
    // Identify lamp: blink, press to solid, press to off, bad code refused
    wr(panel_ctrl_pkg::OFS_IDENT, 32'h2);
    repeat (4) @(posedge ref_clk_in);
    watch;
    chk(32'(k), 32'd16);
    press(2);
    watch;
    chk(32'(k), 32'd32);
    press(2);
    watch;
    chk(32'(k), 32'd0);
    wr(panel_ctrl_pkg::OFS_IDENT, 32'h3);
    rchk(panel_ctrl_pkg::OFS_IDENT, 32'h1);
    rchk(panel_ctrl_pkg::OFS_POWER, 32'h00011308);
    // Firmware serves the off request: no forced-off event, lamps go dark
    wr(panel_ctrl_pkg::OFS_IRQ_CLEAR, 32'h1f);
    press(0);
    wait_for(1, 100);
    rchk(panel_ctrl_pkg::OFS_IRQ_STATUS, 32'h1);
    watch;
    chk(32'(g * 256 + a), 32'h0);
    press(1);
    chk(32'(resets), 32'h1);
    // Wake from the chipset powers up again
    wr(panel_ctrl_pkg::OFS_IRQ_CLEAR, 32'h1f);
    wake_cmd <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    wake_cmd <= 1'b0;
    wait_for(0, 100);
    chk(32'(supply), 32'h1);
    // Firmware ignores the request: off only when the fallback runs out
    serve <= 1'b0;
    wr(panel_ctrl_pkg::OFS_IRQ_CLEAR, 32'h1f);
    press(0);
    repeat (FB - 40) @(posedge ref_clk_in);
    #1 chk(32'(supply), 32'h1);
    rchk(panel_ctrl_pkg::OFS_POWER, 32'h00001310);
    wait_for(1, 60);
    rchk(panel_ctrl_pkg::OFS_IRQ_STATUS, 32'h9);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
